/* File: testbench.sv */
// testbench: reset values, masking, strap, clamp and flags
module testbench import vcr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, sys_rst_i = 1, strap_valid_i = 0;
  logic code_valid_i = 0, status_clear_i = 0, other_fault_o, vout_status_o;
  logic alert_o, rd_valid_o;
  logic [7:0] code_req_i = 0, code_out_o;
  logic [15:0] rd_data_o, d;
  vcr_req_type req;
  vcr_extra_type extra_o;
  logic [7:0] min_o, trim_o;
  logic [3:0] valley_o;
  logic [2:0] pavg_o;
  logic [1:0] cvavg_o;
  logic [15:0] meas = 16'hbeef;
  int n_mismatch = 0, checks = 0, cyc = 0;
  vcr_host host (.clock_i(clock_i), .rd_data_i(rd_data_o), .req_o(req));
  vcr_regs dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .req_i(req),
    .strap_valid_i(strap_valid_i), .limit_strap_pin_i(4'hc),
    .measured_output_mantissa_i(meas), .code_valid_i(code_valid_i),
    .code_req_i(code_req_i), .status_clear_i(status_clear_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .minimum_output_code_o(min_o), .phase_valley_limit_o(valley_o),
    .power_average_time_o(pavg_o), .current_voltage_average_time_o(cvavg_o),
    .output_trim_offset_o(trim_o), .extra_o(extra_o), .code_out_o(code_out_o),
    .other_fault_o(other_fault_o), .vout_status_o(vout_status_o),
    .alert_o(alert_o));
  always #10 clock_i = ~clock_i;
  task automatic check(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    host.access(0, 1, c, 16'h0000, d);
    check(d, e);
  endtask : rd
  task automatic reset_dut(input logic s);
    strap_valid_i = s;
    sys_rst_i = 1;
    repeat (8) @(posedge clock_i);
    #1 sys_rst_i = 0;
  endtask : reset_dut
  task automatic code(input logic [7:0] c, input logic [15:0] e, f);
    @(posedge clock_i);
    #1 {code_valid_i, code_req_i} = {1'b1, c};
    @(posedge clock_i);
    #1 code_valid_i = 0;
    check(code_out_o, e);
    check({other_fault_o, vout_status_o, alert_o}, f);
  endtask : code
  task automatic t_defaults;
    rd(CMD_MIN_CODE, 16'h0000);
    rd(CMD_VALLEY_LIMIT, 16'h0008);
    rd(CMD_TELEM_AVG, 16'h0050);
    rd(CMD_TRIM, 16'h0000);
    rd(CMD_EXTRA_FUNC, 16'h0002);
    check(extra_o, 16'h0002);
    check(min_o, 16'h0000);
    check(valley_o, 16'h0008);
    check(pavg_o, 16'h0005);
    check(cvavg_o, 16'h0000);
    check(trim_o, 16'h0000);
  endtask : t_defaults
  task automatic t_masks;
    logic [7:0] cm[7] = '{8'ha4, 8'hd0, 8'hd1, 8'hd4, 8'hd5, 8'hd7, 8'hd2};
    logic [15:0] ex[7] = '{16'h00ff, 16'h000f, 16'h0073, 16'hbeef,
                           16'h00ff, 16'h0007, 16'h0000};
    foreach (cm[i]) begin
      host.access(1, 1, cm[i], 16'hffff, d);
      rd(cm[i], ex[i]);
    end
    check(extra_o, 16'h0007);
    check(min_o, 16'h00ff);
    check(valley_o, 16'h000f);
    check(pavg_o, 16'h0007);
    check(cvavg_o, 16'h0003);
    check(trim_o, 16'h00ff);
    host.access(0, 0, CMD_MEAS_VOUT, 16'h0000, d);
    check(d, 16'h00ef);
    meas = 16'h1234;
    rd(CMD_MEAS_VOUT, 16'h1234);
  endtask : t_masks
  task automatic t_clamp;
    host.access(1, 1, CMD_MIN_CODE, 16'h0010, d);
    code(8'h05, 16'h0010, 16'h0007);
    @(posedge clock_i);
    #1 status_clear_i = 1;
    @(posedge clock_i);
    #1 status_clear_i = 0;
    code(8'h20, 16'h0020, 16'h0000);
    @(posedge clock_i);
    #1 {code_valid_i, code_req_i, status_clear_i} = {1'b1, 8'h05, 1'b1};
    @(posedge clock_i);
    #1 {code_valid_i, status_clear_i} = 2'b00;
    check({other_fault_o, vout_status_o, alert_o}, 16'h0007);
  endtask : t_clamp
  task automatic t_strap;
    reset_dut(1);
    check({other_fault_o, vout_status_o, alert_o}, 16'h0000);
    repeat (8) @(posedge clock_i);
    rd(CMD_VALLEY_LIMIT, 16'h000c);
    check(valley_o, 16'h000c);
    host.access(1, 0, CMD_VALLEY_LIMIT, 16'h0003, d);
    rd(CMD_VALLEY_LIMIT, 16'h0003);
    check(valley_o, 16'h0003);
  endtask : t_strap
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    reset_dut(0);
    t_defaults();
    t_masks();
    t_clamp();
    t_strap();
    tally_and_finish();
  end
endmodule : testbench

/* File: vcr_checker.sv */
// checker: read answers, masked fields and clamp flags
module vcr_checker
  import vcr_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        sys_rst_i,
  input wire vcr_req_type req_i,
  input wire logic        code_valid_i,
  input wire logic [7:0]  code_req_i,
  input wire logic        status_clear_i,
  input wire logic [15:0] rd_data_o,
  input wire logic        rd_valid_o,
  input wire logic [7:0]  minimum_output_code_o,
  input wire logic [7:0]  code_out_o,
  input wire logic        other_fault_o,
  input wire logic        alert_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // the field copy lags the register one cycle, so skip the cycle after a
  // minimum write, where the design already compares against the new limit
  sequence s_low;
    code_valid_i && code_req_i < minimum_output_code_o
      && !$past(req_i.wr && req_i.cmd == CMD_MIN_CODE);
  endsequence
  sequence s_high;
    code_valid_i && code_req_i >= minimum_output_code_o
      && !$past(req_i.wr && req_i.cmd == CMD_MIN_CODE);
  endsequence
  property p_mask(c, m);
    rd_valid_o && $past(req_i.rd) && $past(req_i.cmd) == c
      |-> (rd_data_o & ~m) == 16'h0000;
  endproperty
  a_read_answer: assert property (req_i.rd |=> rd_valid_o)
    else $error("read not answered");
  a_min_mask: assert property (p_mask(CMD_MIN_CODE, 16'h00ff))
    else $error("minimum code high byte not zero");
  a_valley_mask: assert property (p_mask(CMD_VALLEY_LIMIT, 16'h000f))
    else $error("valley reserved bits not zero");
  a_avg_mask: assert property (p_mask(CMD_TELEM_AVG, 16'h0073))
    else $error("averaging reserved bits not zero");
  a_extra_mask: assert property (p_mask(CMD_EXTRA_FUNC, 16'h0007))
    else $error("extra reserved bits not zero");
  a_low_clamp: assert property (s_low |=> code_out_o == $past(minimum_output_code_o))
    else $error("low code not clamped");
  a_low_flags: assert property (s_low |=> other_fault_o && alert_o)
    else $error("clamp flags not raised");
  a_high_pass: assert property (s_high |=> code_out_o == $past(code_req_i))
    else $error("legal code altered");
  a_alert_sticky: assert property (alert_o && !status_clear_i |=> alert_o)
    else $error("alert dropped without clear");
endmodule : vcr_checker

bind vcr_regs vcr_checker u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .req_i(req_i), .code_valid_i(code_valid_i), .code_req_i(code_req_i),
  .status_clear_i(status_clear_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .minimum_output_code_o(minimum_output_code_o),
  .code_out_o(code_out_o), .other_fault_o(other_fault_o), .alert_o(alert_o));

/* File: vcr_host.sv */
// host model: one register request per call, held for one edge
module vcr_host
  import vcr_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic [15:0] rd_data_i,
  output vcr_req_type      req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;
  task automatic access(input logic wr, word, input logic [7:0] cmd,
                        input logic [15:0] data, output logic [15:0] rdat);
    @(posedge clock_i);
    #1 req_o = {wr, !wr, word, cmd, data};
    @(posedge clock_i);
    #1 req_o = '0;
    rdat = rd_data_i;
  endtask : access
endmodule : vcr_host

/* File: vcr_pkg.sv */
// package: command codes, field layouts and defaults of the config registers
package vcr_pkg;
  localparam logic [7:0]  CMD_MIN_CODE     = 8'ha4;
  localparam logic [7:0]  CMD_VALLEY_LIMIT = 8'hd0;
  localparam logic [7:0]  CMD_TELEM_AVG    = 8'hd1;
  localparam logic [7:0]  CMD_MEAS_VOUT    = 8'hd4;
  localparam logic [7:0]  CMD_TRIM         = 8'hd5;
  localparam logic [7:0]  CMD_EXTRA_FUNC   = 8'hd7;
  localparam logic [7:0]  MIN_CODE_RST     = 8'h00;
  localparam logic [7:0]  VALLEY_NVM_RST   = 8'h08;
  localparam logic [7:0]  VALLEY_MASK      = 8'h0f;
  localparam logic [7:0]  TELEM_AVG_RST    = 8'h50;
  localparam logic [7:0]  TELEM_AVG_MASK   = 8'h73;
  localparam logic [7:0]  TRIM_RST         = 8'h00;
  localparam logic [7:0]  EXTRA_FUNC_RST   = 8'h02;
  localparam logic [7:0]  EXTRA_FUNC_MASK  = 8'h07;
  localparam int          EXTRA_FAST_BIT   = 2;
  localparam int          EXTRA_BRAKE_BIT  = 1;
  localparam int          EXTRA_SOFT_BIT   = 0;
  localparam int          VALLEY_HI        = 3;
  localparam int          PAVG_HI          = 6;
  localparam int          PAVG_LO          = 4;
  localparam int          CVAVG_HI         = 1;
  localparam int          CVAVG_LO         = 0;
  localparam logic [15:0] UNMAPPED_DATA    = 16'h0000;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        word;
    logic [7:0]  cmd;
    logic [15:0] data;
  } vcr_req_type;

  typedef struct packed {
    logic       fast_slew;
    logic       body_braking;
    logic       soft_start_slow;
  } vcr_extra_type;
endpackage : vcr_pkg

/* File: vcr_regs.sv */
// vcr_regs: configuration and telemetry command registers
module vcr_regs
  import vcr_pkg::*;
(
  input  wire logic          clock_i,
  input  wire logic          sys_rst_i,
  input  wire vcr_req_type   req_i,
  input  wire logic          strap_valid_i,
  input  wire logic [3:0]    limit_strap_pin_i,
  input  wire logic [15:0]   measured_output_mantissa_i,
  input  wire logic          code_valid_i,
  input  wire logic [7:0]    code_req_i,
  input  wire logic          status_clear_i,
  output logic [15:0]        rd_data_o,
  output logic               rd_valid_o,
  output logic [7:0]         minimum_output_code_o,
  output logic [3:0]         phase_valley_limit_o,
  output logic [2:0]         power_average_time_o,
  output logic [1:0]         current_voltage_average_time_o,
  output logic [7:0]         output_trim_offset_o,
  output vcr_extra_type      extra_o,
  output logic [7:0]         code_out_o,
  output logic               other_fault_o,
  output logic               vout_status_o,
  output logic               alert_o
);
  logic [7:0]  min_code_r;
  logic [7:0]  valley_r;
  logic [7:0]  telem_r;
  logic [7:0]  trim_r;
  logic [7:0]  extra_r;
  logic        host_wrote_valley_r;
  logic [2:0]  strap_sync_r;
  logic [15:0] meas_r;
  logic [15:0] rd_nxt;
  logic        below_min;

  // elaboration checks: a reset value that its own write mask clears would
  // read back differently after reset than after an equal host write
  if ((VALLEY_NVM_RST & ~VALLEY_MASK) != 8'h00) begin : g_valley_rst_chk
    $error("valley reset value has reserved bits set");
  end
  if ((TELEM_AVG_RST & ~TELEM_AVG_MASK) != 8'h00) begin : g_telem_rst_chk
    $error("averaging reset value has reserved bits set");
  end
  if ((EXTRA_FUNC_RST & ~EXTRA_FUNC_MASK) != 8'h00) begin : g_extra_rst_chk
    $error("extra function reset value has reserved bits set");
  end

  // the strap loads the whole valley field, so both must be equally wide
  if (VALLEY_HI + 1 != $bits(limit_strap_pin_i)) begin : g_valley_fld_chk
    $error("valley field width differs from the strap width");
  end

  // averaging fields must not overlap, and must fit the byte and the outputs
  localparam int PAVG_W  = PAVG_HI - PAVG_LO + 1;
  localparam int CVAVG_W = CVAVG_HI - CVAVG_LO + 1;
  if (PAVG_LO <= CVAVG_HI || PAVG_HI >= $bits(telem_r)) begin : g_avg_fld_chk
    $error("averaging fields overlap or leave the byte");
  end
  if ($bits(power_average_time_o) != PAVG_W ||
      $bits(current_voltage_average_time_o) != CVAVG_W) begin : g_avg_w_chk
    $error("averaging output width differs from its field");
  end

  // a control bit outside the write mask could never be set by the host
  if (!EXTRA_FUNC_MASK[EXTRA_FAST_BIT] || !EXTRA_FUNC_MASK[EXTRA_BRAKE_BIT] ||
      !EXTRA_FUNC_MASK[EXTRA_SOFT_BIT]) begin : g_extra_fld_chk
    $error("extra function bit outside its write mask");
  end

  // a duplicated command code would shadow a register in the read decode
  localparam int         NUM_CMDS = 6;
  localparam logic [7:0] CMD_LIST [NUM_CMDS] = '{CMD_MIN_CODE,
    CMD_VALLEY_LIMIT, CMD_TELEM_AVG, CMD_MEAS_VOUT, CMD_TRIM, CMD_EXTRA_FUNC};
  for (genvar i = 0; i < NUM_CMDS; i++) begin : g_cmd_outer
    for (genvar j = i + 1; j < NUM_CMDS; j++) begin : g_cmd_inner
      if (CMD_LIST[i] == CMD_LIST[j]) begin : g_cmd_chk
        $error("two registers share one command code");
      end
    end
  end

  // strap arrives from a pin; three stages, accept once the last two are both high
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_sync_r <= 3'h0;
    end else begin
      strap_sync_r <= {strap_sync_r[1:0], strap_valid_i};
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      min_code_r <= MIN_CODE_RST;
    end else if (req_i.wr && req_i.cmd == CMD_MIN_CODE) begin
      min_code_r <= req_i.data[7:0];
    end
  end

  // strap level is sampled after reset release, only until the host writes
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      valley_r            <= VALLEY_NVM_RST;
      host_wrote_valley_r <= 1'b0;
    end else if (req_i.wr && req_i.cmd == CMD_VALLEY_LIMIT) begin
      valley_r            <= req_i.data[7:0] & VALLEY_MASK;
      host_wrote_valley_r <= 1'b1;
    end else if (!host_wrote_valley_r && strap_sync_r[2] && strap_sync_r[1])
    begin
      valley_r <= {4'h0, limit_strap_pin_i};
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      telem_r <= TELEM_AVG_RST;
    end else if (req_i.wr && req_i.cmd == CMD_TELEM_AVG) begin
      telem_r <= req_i.data[7:0] & TELEM_AVG_MASK;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trim_r <= TRIM_RST;
    end else if (req_i.wr && req_i.cmd == CMD_TRIM) begin
      trim_r <= req_i.data[7:0];
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      extra_r <= EXTRA_FUNC_RST;
    end else if (req_i.wr && req_i.cmd == CMD_EXTRA_FUNC) begin
      extra_r <= req_i.data[7:0] & EXTRA_FUNC_MASK;
    end
  end

  // measured value is registered so a word read is never torn
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meas_r <= 16'h0000;
    end else begin
      meas_r <= measured_output_mantissa_i;
    end
  end

  always_comb begin
    rd_nxt = UNMAPPED_DATA;
    unique case (req_i.cmd)
      CMD_MIN_CODE:     rd_nxt = {8'h00, min_code_r};
      CMD_VALLEY_LIMIT: rd_nxt = {8'h00, valley_r};
      CMD_TELEM_AVG:    rd_nxt = {8'h00, telem_r};
      CMD_MEAS_VOUT:    rd_nxt = meas_r;
      CMD_TRIM:         rd_nxt = {8'h00, trim_r};
      CMD_EXTRA_FUNC:   rd_nxt = {8'h00, extra_r};
      default:          rd_nxt = UNMAPPED_DATA;
    endcase
    if (!req_i.word) begin
      rd_nxt = {8'h00, rd_nxt[7:0]};
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o  <= 16'h0000;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= req_i.rd;
      if (req_i.rd) begin
        rd_data_o <= rd_nxt;
      end
    end
  end

  assign below_min = code_req_i < min_code_r;

  // clamp; a new event wins over a same-cycle clear
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      code_out_o    <= 8'h00;
      other_fault_o <= 1'b0;
      vout_status_o <= 1'b0;
      alert_o       <= 1'b0;
    end else begin
      if (code_valid_i) begin
        code_out_o <= below_min ? min_code_r : code_req_i;
      end
      if (code_valid_i && below_min) begin
        other_fault_o <= 1'b1;
        vout_status_o <= 1'b1;
        alert_o       <= 1'b1;
      end else if (status_clear_i) begin
        other_fault_o <= 1'b0;
        vout_status_o <= 1'b0;
        alert_o       <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      minimum_output_code_o          <= MIN_CODE_RST;
      phase_valley_limit_o           <= 4'h0;
      power_average_time_o           <= 3'h0;
      current_voltage_average_time_o <= 2'h0;
      output_trim_offset_o           <= TRIM_RST;
      extra_o                        <= '0;
    end else begin
      minimum_output_code_o          <= min_code_r;
      phase_valley_limit_o           <= valley_r[VALLEY_HI:0];
      power_average_time_o           <= telem_r[PAVG_HI:PAVG_LO];
      current_voltage_average_time_o <= telem_r[CVAVG_HI:CVAVG_LO];
      output_trim_offset_o           <= trim_r;
      extra_o.fast_slew              <= extra_r[EXTRA_FAST_BIT];
      extra_o.body_braking           <= extra_r[EXTRA_BRAKE_BIT];
      extra_o.soft_start_slow        <= extra_r[EXTRA_SOFT_BIT];
    end
  end
endmodule : vcr_regs
